// File: logic/mcc_top.sv
// Main clock controller: CPU prescaler, clock-out, time base and beeper on APB.
// Assumes pclk is the oscillator clock and the power requests are synchronous.
module mcc_top #(
  parameter logic [17:0] TB_DIV0    = mcc_pkg::TB_DIV_0,
  parameter logic [17:0] TB_DIV1    = mcc_pkg::TB_DIV_1,
  parameter logic [17:0] TB_DIV2    = mcc_pkg::TB_DIV_2,
  parameter logic [17:0] TB_DIV3    = mcc_pkg::TB_DIV_3,
  parameter logic [13:0] TONE_HALF1 = mcc_pkg::TONE_HALF_1,
  parameter logic [13:0] TONE_HALF2 = mcc_pkg::TONE_HALF_2,
  parameter logic [13:0] TONE_HALF3 = mcc_pkg::TONE_HALF_3
) (
  // Clock, reset, enable
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        ce,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Power mode requests from the CPU and the external wake input
  input  wire logic        wait_req,
  input  wire logic        halt_req,
  input  wire logic        ext_wake,
  // Clocks and pins
  output logic             cpu_tick,
  output logic             clock_out_pin,
  output logic             clock_out_oe,
  output logic             tone_pin,
  output logic             tone_oe,
  // Interrupt and power status
  output logic             irq,
  output logic             wake,
  output mcc_pkg::mcc_pmode_t power_mode
);
  import mcc_pkg::*;

  mcc_core_if core ();

  // Register state
  logic       clock_out_enable_q;
  logic [1:0] cpu_divider_select_q;
  logic       slow_select_q;
  logic [1:0] time_base_select_q;
  logic       timeout_irq_enable_q;
  logic       timeout_flag_q;
  logic [1:0] tone_select_q;
  logic       irq_status_q;
  logic       irq_mask_q;

  // Bus state
  logic        pready_q;
  logic        pslverr_q;
  logic [31:0] prdata_q;

  // Power and clock state
  mcc_pmode_t  pm_q;
  mcc_pmode_t  pm_d;
  logic        wake_q;
  logic [3:0]  cpu_cnt_q;
  logic        cpu_tick_q;
  logic        clock_out_pin_q;
  logic        clock_out_oe_q;
  logic        tone_pin_q;
  logic        tone_oe_q;
  logic        irq_q;

  // Decode
  logic        xfer;
  logic        wr;
  logic        rd;
  logic        hit_csr;
  logic        hit_tone;
  logic        hit_ists;
  logic        hit_imsk;
  logic        mapped;
  logic        frozen;
  logic        cpu_running;
  logic        wake_evt;
  logic [7:0]  csr_view;
  logic [31:0] rd_mux;
  logic [3:0]  cpu_last;

  // Completing edge: master sees pready high, so writes and read side effects land here
  assign xfer     = psel && penable && pready_q;
  assign wr       = xfer && pwrite && !frozen;
  assign rd       = xfer && !pwrite;
  assign hit_csr  = (paddr[11:2] == IDX_CSR);
  assign hit_tone = (paddr[11:2] == IDX_TONE);
  assign hit_ists = (paddr[11:2] == IDX_IRQ_STATUS);
  assign hit_imsk = (paddr[11:2] == IDX_IRQ_MASK);
  assign mapped   = hit_csr || hit_tone || hit_ists || hit_imsk;

  // Active halt and halt both block register writes; the interrupt status clear and the tick-set flags still act
  assign frozen      = (pm_q == PM_ACTIVE_HALT) || (pm_q == PM_HALT);
  assign cpu_running = (pm_q == PM_RUN) || (pm_q == PM_WAIT);
  assign wake_evt    = (core.tb_tick && timeout_irq_enable_q) || ext_wake;

  // Engines
  assign core.run_rtc  = (pm_q != PM_HALT);
  assign core.run_tone = (pm_q != PM_HALT);
  assign core.tb_sel   = time_base_select_q;
  assign core.tone_sel = tone_select_q;

  mcc_rtc #(
    .DIV0 (TB_DIV0),
    .DIV1 (TB_DIV1),
    .DIV2 (TB_DIV2),
    .DIV3 (TB_DIV3)
  ) u_rtc (
    .pclk    (pclk),
    .presetn (presetn),
    .ce      (ce),
    .core    (core.rtc)
  );

  mcc_tone #(
    .HALF1 (TONE_HALF1),
    .HALF2 (TONE_HALF2),
    .HALF3 (TONE_HALF3)
  ) u_tone (
    .pclk    (pclk),
    .presetn (presetn),
    .ce      (ce),
    .core    (core.tone)
  );

  // Control/status register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clock_out_enable_q   <= CSR_RESET[CSR_CLKOUT_BIT];
      cpu_divider_select_q <= CSR_RESET[CSR_CPUDIV_LSB +: 2];
      slow_select_q        <= CSR_RESET[CSR_SLOW_BIT];
      time_base_select_q   <= CSR_RESET[CSR_TB_LSB +: 2];
      timeout_irq_enable_q <= CSR_RESET[CSR_OIE_BIT];
    end else if (ce && wr && hit_csr) begin
      clock_out_enable_q   <= pwdata[CSR_CLKOUT_BIT];
      cpu_divider_select_q <= pwdata[CSR_CPUDIV_LSB +: 2];
      slow_select_q        <= pwdata[CSR_SLOW_BIT];
      time_base_select_q   <= pwdata[CSR_TB_LSB +: 2];
      timeout_irq_enable_q <= pwdata[CSR_OIE_BIT];
    end
  end

  // Timeout flag: a tick in the same cycle as the clearing read wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timeout_flag_q <= CSR_RESET[CSR_FLAG_BIT];
    end else if (ce) begin
      if (core.tb_tick) begin
        timeout_flag_q <= 1'b1;
      end else if (rd && hit_csr) begin
        timeout_flag_q <= 1'b0;
      end
    end
  end

  // Tone register; only the select field is stored, upper bits read zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tone_select_q <= TONE_RESET[TONE_SEL_LSB +: 2];
    end else if (ce && wr && hit_tone) begin
      tone_select_q <= pwdata[TONE_SEL_LSB +: 2];
    end
  end

  // Interrupt status (write one to clear, set wins) and mask
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_status_q <= IRQ_RESET;
    end else if (ce) begin
      if (core.tb_tick) begin
        irq_status_q <= 1'b1;
      end else if (xfer && pwrite && hit_ists && pwdata[IRQ_TIMEOUT_BIT]) begin
        irq_status_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_mask_q <= IRQ_RESET;
    end else if (ce && wr && hit_imsk) begin
      irq_mask_q <= pwdata[IRQ_TIMEOUT_BIT];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_q <= 1'b0;
    end else if (ce) begin
      irq_q <= irq_status_q && irq_mask_q;
    end
  end

  // Read data
  assign csr_view = {clock_out_enable_q, cpu_divider_select_q, slow_select_q,
                     time_base_select_q, timeout_irq_enable_q, timeout_flag_q};

  always_comb begin
    rd_mux = 32'h00000000;
    if (hit_csr) begin
      rd_mux[7:0] = csr_view;
    end else if (hit_tone) begin
      rd_mux[TONE_SEL_LSB +: 2] = tone_select_q;
    end else if (hit_ists) begin
      rd_mux[IRQ_TIMEOUT_BIT] = irq_status_q;
    end else if (hit_imsk) begin
      rd_mux[IRQ_TIMEOUT_BIT] = irq_mask_q;
    end
  end

  // One wait state: pready rises in the second access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h00000000;
    end else if (ce) begin
      pready_q <= psel && penable && !pready_q;
      if (psel && penable && !pready_q) begin
        pslverr_q <= !mapped;
        prdata_q  <= pwrite ? 32'h00000000 : rd_mux;
      end else begin
        pslverr_q <= 1'b0;
      end
    end
  end

  // Power mode sequencing
  always_comb begin
    pm_d = pm_q;
    unique case (pm_q)
      PM_RUN: begin
        if (halt_req) begin
          pm_d = timeout_irq_enable_q ? PM_ACTIVE_HALT : PM_HALT;
        end else if (wait_req) begin
          pm_d = PM_WAIT;
        end
      end
      PM_WAIT: begin
        if (wake_evt) begin
          pm_d = PM_RUN;
        end
      end
      PM_ACTIVE_HALT: begin
        if (wake_evt) begin
          pm_d = PM_RUN;
        end
      end
      PM_HALT: begin
        if (ext_wake) begin
          pm_d = PM_RUN; // Timeout cannot run here
        end
      end
      default: pm_d = PM_RUN;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pm_q   <= PM_RUN;
      wake_q <= 1'b0;
    end else if (ce) begin
      pm_q   <= pm_d;
      wake_q <= (pm_q != PM_RUN) && (pm_d == PM_RUN);
    end
  end

  // CPU prescaler: one tick per CPU clock period
  // Shift amount is three bits wide so that code 11 reaches a shift of 4 instead of wrapping to 0
  assign cpu_last = 4'((5'b00001 << (3'(cpu_divider_select_q) + 3'(CPU_DIV_LOG2_MIN))) - 5'd1);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cpu_cnt_q  <= 4'h0;
      cpu_tick_q <= 1'b0;
    end else if (ce) begin
      if (!cpu_running) begin
        cpu_cnt_q  <= 4'h0;
        cpu_tick_q <= 1'b0;
      end else if (!slow_select_q) begin
        cpu_cnt_q  <= 4'h0;
        cpu_tick_q <= 1'b1;
      end else if (cpu_cnt_q >= cpu_last) begin
        cpu_cnt_q  <= 4'h0;
        cpu_tick_q <= 1'b1;
      end else begin
        cpu_cnt_q  <= cpu_cnt_q + 4'd1;
        cpu_tick_q <= 1'b0;
      end
    end
  end

  // Clock-out pin: toggles per CPU tick, so it runs at half the CPU rate
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clock_out_pin_q <= 1'b0;
      clock_out_oe_q  <= 1'b0;
    end else if (ce) begin
      clock_out_oe_q <= clock_out_enable_q && cpu_running;
      if (!(clock_out_enable_q && cpu_running)) begin
        clock_out_pin_q <= 1'b0;
      end else if (cpu_tick_q) begin
        clock_out_pin_q <= ~clock_out_pin_q;
      end
    end
  end

  // Tone pin
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tone_pin_q <= 1'b0;
      tone_oe_q  <= 1'b0;
    end else if (ce) begin
      tone_pin_q <= core.tone_out;
      tone_oe_q  <= (tone_select_q != 2'b00);
    end
  end

  // Outputs
  assign prdata        = prdata_q;
  assign pready        = pready_q;
  assign pslverr       = pslverr_q;
  assign cpu_tick      = cpu_tick_q;
  assign clock_out_pin = clock_out_pin_q;
  assign clock_out_oe  = clock_out_oe_q;
  assign tone_pin      = tone_pin_q;
  assign tone_oe       = tone_oe_q;
  assign irq           = irq_q;
  assign wake          = wake_q;
  assign power_mode    = pm_q;

endmodule : mcc_top

// File: inc/mcc_pkg.sv
// Constants, field layout and mode encodings of the clock controller.
// Assumes pclk is the oscillator clock and every count below is in its cycles.
package mcc_pkg;

  // Register indices; the byte address on APB is four times the index
  localparam logic [9:0]  IDX_CSR        = 10'h02C;
  localparam logic [9:0]  IDX_TONE       = 10'h02D;
  localparam logic [9:0]  IDX_IRQ_STATUS = 10'h02E;
  localparam logic [9:0]  IDX_IRQ_MASK   = 10'h02F;

  // Control/status field positions
  localparam int unsigned CSR_CLKOUT_BIT = 7;
  localparam int unsigned CSR_CPUDIV_LSB = 5;
  localparam int unsigned CSR_SLOW_BIT   = 4;
  localparam int unsigned CSR_TB_LSB     = 2;
  localparam int unsigned CSR_OIE_BIT    = 1;
  localparam int unsigned CSR_FLAG_BIT   = 0;
  localparam int unsigned TONE_SEL_LSB   = 0;
  localparam int unsigned IRQ_TIMEOUT_BIT = 0;

  // Reset values
  localparam logic [7:0]  CSR_RESET      = 8'h00;
  localparam logic [7:0]  TONE_RESET     = 8'h00;
  localparam logic        IRQ_RESET      = 1'b0;

  // Time base dividers in oscillator cycles
  localparam logic [17:0] TB_DIV_0       = 18'd16000;
  localparam logic [17:0] TB_DIV_1       = 18'd32000;
  localparam logic [17:0] TB_DIV_2       = 18'd80000;
  localparam logic [17:0] TB_DIV_3       = 18'd200000;

  // Tone half periods in oscillator cycles (ratios for an 8 MHz oscillator)
  localparam logic [13:0] TONE_HALF_1    = 14'd2000;
  localparam logic [13:0] TONE_HALF_2    = 14'd4000;
  localparam logic [13:0] TONE_HALF_3    = 14'd8000;

  // Slow mode divides by 2 to the power (code + this)
  localparam int unsigned CPU_DIV_LOG2_MIN = 1;

  typedef enum logic [3:0] {
    PM_RUN         = 4'b0001,
    PM_WAIT        = 4'b0010,
    PM_ACTIVE_HALT = 4'b0100,
    PM_HALT        = 4'b1000
  } mcc_pmode_t;

endpackage : mcc_pkg

// File: inc/mcc_core_if.sv
// Signals shared by the controller top and its time base and tone engines.
// Assumes all three sit on the same pclk domain.
interface mcc_core_if;
  logic       run_rtc;
  logic       run_tone;
  logic [1:0] tb_sel;
  logic       tb_tick;
  logic [1:0] tone_sel;
  logic       tone_out;

  modport ctl  (output run_rtc, output run_tone, output tb_sel, output tone_sel,
                input tb_tick, input tone_out);
  modport rtc  (input run_rtc, input tb_sel, output tb_tick);
  modport tone (input run_tone, input tone_sel, output tone_out);
endinterface : mcc_core_if

// File: logic/mcc_rtc.sv
// Time base counter: counts oscillator cycles and pulses once per period.
// Assumes run_rtc is low in full stop; the clock enable from the top gates the counter and tick here.
module mcc_rtc #(
  parameter logic [17:0] DIV0 = mcc_pkg::TB_DIV_0,
  parameter logic [17:0] DIV1 = mcc_pkg::TB_DIV_1,
  parameter logic [17:0] DIV2 = mcc_pkg::TB_DIV_2,
  parameter logic [17:0] DIV3 = mcc_pkg::TB_DIV_3
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // Core link
  mcc_core_if.rtc  core
);
  import mcc_pkg::*;

  logic [17:0] cnt_q;
  logic [1:0]  sel_q;
  logic        tick_q;
  logic [17:0] last;
  logic        at_last;

  always_comb begin
    unique case (sel_q)
      2'b00: last = DIV0 - 18'd1;
      2'b01: last = DIV1 - 18'd1;
      2'b10: last = DIV2 - 18'd1;
      2'b11: last = DIV3 - 18'd1;
    endcase
  end

  assign at_last = (cnt_q == last);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= 18'h00000;
      sel_q <= 2'b00;
    end else if (ce && core.run_rtc) begin
      if (at_last) begin
        cnt_q <= 18'h00000;
        sel_q <= core.tb_sel; // New base only at period end
      end else begin
        cnt_q <= cnt_q + 18'd1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_q <= 1'b0;
    end else if (ce) begin
      tick_q <= core.run_rtc && at_last;
    end
  end

  assign core.tb_tick = tick_q;

endmodule : mcc_rtc

// File: logic/mcc_tone.sv
// Beep generator: square wave from a half-period counter on the oscillator.
// Assumes run_tone is low only in full stop.
module mcc_tone #(
  parameter logic [13:0] HALF1 = mcc_pkg::TONE_HALF_1,
  parameter logic [13:0] HALF2 = mcc_pkg::TONE_HALF_2,
  parameter logic [13:0] HALF3 = mcc_pkg::TONE_HALF_3
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // Core link
  mcc_core_if.tone core
);
  import mcc_pkg::*;

  logic [13:0] cnt_q;
  logic        out_q;
  logic [13:0] last;

  always_comb begin
    unique case (core.tone_sel)
      2'b00: last = 14'h0000;
      2'b01: last = HALF1 - 14'd1;
      2'b10: last = HALF2 - 14'd1;
      2'b11: last = HALF3 - 14'd1;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= 14'h0000;
      out_q <= 1'b0;
    end else if (ce && core.run_tone) begin
      if (core.tone_sel == 2'b00) begin
        cnt_q <= 14'h0000;
        out_q <= 1'b0;
      end else if (cnt_q >= last) begin
        // >= so a switch to a shorter tone cannot overrun the counter
        cnt_q <= 14'h0000;
        out_q <= ~out_q;
      end else begin
        cnt_q <= cnt_q + 14'd1;
      end
    end
  end

  assign core.tone_out = out_q;

endmodule : mcc_tone

// File: sim/mcc_pin_listener.sv
// Load on the clock-out and tone pins: counts edges, measures tone half period.
// Assumes both pins change only on pclk edges.
module mcc_pin_listener (
  // Clock
  input  wire logic   pclk,
  // Pins watched
  input  wire logic   clock_out_pin,
  input  wire logic   tone_pin,
  // Measurements
  output int unsigned tone_half,
  output int unsigned tone_edges,
  output int unsigned clk_edges
);
  timeunit 1ns;
  timeprecision 1ps;
  logic        tone_q;
  logic        clk_q;
  int unsigned run_q;

  // Sampled on pclk, so a pin faster than half pclk would alias
  always_ff @(posedge pclk) begin
    tone_q <= tone_pin;
    clk_q  <= clock_out_pin;
    run_q  <= (tone_pin !== tone_q) ? 1 : run_q + 1;
    if (tone_pin !== tone_q) begin
      tone_half  <= run_q;
      tone_edges <= tone_edges + 1;
    end
    if (clock_out_pin !== clk_q) begin
      clk_edges <= clk_edges + 1;
    end
  end
endmodule : mcc_pin_listener

// File: sim/mcc_top_properties.sv
// Checker of the clock controller pins and power modes, bound to mcc_top.
// Assumes ce drops only briefly in normal mode, so every bound is in pclk cycles.
module mcc_checker (
  // Clock and reset
  input wire logic                pclk,
  input wire logic                presetn,
  input wire logic                ce,
  // Power requests
  input wire logic                halt_req,
  input wire logic                ext_wake,
  // Pins and status
  input wire logic                cpu_tick,
  input wire logic                clock_out_pin,
  input wire logic                clock_out_oe,
  input wire logic                tone_pin,
  input wire logic                tone_oe,
  input wire logic                wake,
  input wire mcc_pkg::mcc_pmode_t power_mode
);
  timeunit 1ns;
  timeprecision 1ps;
  import mcc_pkg::*;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic halted;
  assign halted = (power_mode == PM_ACTIVE_HALT) || (power_mode == PM_HALT);

  a_clkout_idle_low: assert property (!clock_out_oe [*2] |-> !clock_out_pin)
    else $error("clock-out pin high while released");
  a_clkout_off_halt: assert property ((power_mode == PM_ACTIVE_HALT) [*2] |-> !clock_out_oe)
    else $error("clock-out driven in active halt");
  a_tick_stop_halt: assert property (halted [*2] |-> !cpu_tick)
    else $error("cpu tick while halted");
  a_tick_run_bound: assert property (power_mode == PM_RUN |-> ##[0:16] (cpu_tick || power_mode != PM_RUN))
    else $error("no cpu tick within 16 cycles");
  a_halt_entry: assert property (ce && power_mode == PM_RUN && halt_req |=> halted)
    else $error("halt request not taken");
  a_halt_stays: assert property (ce && power_mode == PM_HALT && !ext_wake |=> power_mode == PM_HALT)
    else $error("halt left without external wake");
  a_wake_on_return: assert property (power_mode == PM_RUN && $past(power_mode) != PM_RUN |-> ##[0:1] wake)
    else $error("no wake pulse on return to run");
  a_tone_idle_low: assert property (!tone_oe [*2] |-> !tone_pin)
    else $error("tone pin high while off");

  c_active_halt: cover property (power_mode == PM_ACTIVE_HALT ##1 power_mode == PM_RUN);
  c_full_halt: cover property (power_mode == PM_HALT ##1 power_mode == PM_RUN);
  c_wait: cover property (power_mode == PM_WAIT);
endmodule : mcc_checker

bind mcc_top mcc_checker u_mcc_checker (
  .pclk(pclk), .presetn(presetn), .ce(ce), .halt_req(halt_req), .ext_wake(ext_wake), .cpu_tick(cpu_tick),
  .clock_out_pin(clock_out_pin), .clock_out_oe(clock_out_oe), .tone_pin(tone_pin), .tone_oe(tone_oe),
  .wake(wake), .power_mode(power_mode)
);

// File: sim/main_clock_rtc_beeper_tb.sv
// Testbench of the clock controller: register rows, time base, tone, clock-out, power modes.
// Assumes shortened time base and slowest tone at the instance; ce drops once to test the freeze.
module main_clock_rtc_beeper_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import mcc_pkg::*;
`define MCC_CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin err_count++; \
  $display("mismatch %s expected %0h seen %0h", nm, e, g); end end

  typedef struct {logic [9:0] idx; logic [7:0] wd, ex, m; logic er; int ticks;} mcc_row_t;
  localparam int DIV [4]  = '{16, 32, 80, 200};
  // Two fast tones keep their default half periods, the slowest one is shortened
  localparam int HALF [4] = '{0, TONE_HALF_1, TONE_HALF_2, 8};
  logic        pclk, presetn, ce, psel, penable, pwrite, wait_req, halt_req, ext_wake, er;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        pready, pslverr, cpu_tick, clock_out_pin, clock_out_oe, tone_pin, tone_oe, irq, wake;
  mcc_pmode_t  power_mode;
  int unsigned tone_half, tone_edges, clk_edges;
  int          err_count, checks_done, cyc, t0, t1, t2, n, p;
  int          codes [4] = '{3, 0, 1, 2};
  // Whole-byte writes only: a read-modify-write would clear the flag
  mcc_row_t    rows [10] = '{
    '{IDX_CSR, 8'h80, 8'h80, 8'hFE, 1'h0, 64}, '{IDX_CSR, 8'h90, 8'h90, 8'hFE, 1'h0, 32},
    '{IDX_CSR, 8'hB0, 8'hB0, 8'hFE, 1'h0, 16}, '{IDX_CSR, 8'hD0, 8'hD0, 8'hFE, 1'h0, 8},
    '{IDX_CSR, 8'hF0, 8'hF0, 8'hFE, 1'h0, 4}, '{IDX_CSR, 8'h11, 8'h10, 8'hFE, 1'h0, 32},
    '{IDX_TONE, 8'h03, 8'h03, 8'hFF, 1'h0, -1}, '{IDX_TONE, 8'h00, 8'h00, 8'hFF, 1'h0, -1},
    '{IDX_IRQ_MASK, 8'h01, 8'h01, 8'hFF, 1'h0, -1}, '{10'h030, 8'h5A, 8'h00, 8'hFF, 1'h1, -1}};

  mcc_top #(.TB_DIV0(18'h10), .TB_DIV1(18'h20), .TB_DIV2(18'h50), .TB_DIV3(18'hC8),
    .TONE_HALF3(14'h8)) u_mcc_top (
    .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .wait_req(wait_req), .halt_req(halt_req), .ext_wake(ext_wake), .cpu_tick(cpu_tick),
    .clock_out_pin(clock_out_pin), .clock_out_oe(clock_out_oe), .tone_pin(tone_pin), .tone_oe(tone_oe),
    .irq(irq), .wake(wake), .power_mode(power_mode));
  mcc_pin_listener u_mcc_pin_listener (.pclk(pclk), .clock_out_pin(clock_out_pin), .tone_pin(tone_pin),
    .tone_half(tone_half), .tone_edges(tone_edges), .clk_edges(clk_edges));

  initial begin
    pclk = 1'h0;
    forever #2.5 pclk = ~pclk;
  end
  always @(posedge pclk) cyc++;

  task automatic apb(input logic w, input logic [9:0] idx, input logic [7:0] d);
    @(posedge pclk);
    psel <= 1'h1; penable <= 1'h0; pwrite <= w; paddr <= {idx, 2'h0}; pwdata <= {24'h000000, d};
    @(posedge pclk);
    penable <= 1'h1;
    // Only the watchdog ends a wait for the answer
    do begin
      @(posedge pclk);
    end while (pready !== 1'h1);
    rd = prdata;
    er = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask : apb

  // Timestamp of the next time base event, then clear it
  task automatic wait_irq(output int t);
    int k;
    k = 0;
    repeat (3) @(negedge pclk);
    while (irq !== 1'h1 && k < 1000) begin
      @(negedge pclk);
      k++;
    end
    t = cyc;
    apb(1'h1, IDX_IRQ_STATUS, 8'h01);
  endtask : wait_irq

  task automatic power_req(input logic h, input logic w, input logic x);
    @(posedge pclk);
    halt_req <= h; wait_req <= w; ext_wake <= x;
    @(posedge pclk);
    halt_req <= 1'h0; wait_req <= 1'h0; ext_wake <= 1'h0;
    @(negedge pclk);
  endtask : power_req

  task automatic until_run;
    int k;
    k = 0;
    while (power_mode !== PM_RUN && k < 300) begin
      @(negedge pclk);
      k++;
    end
  endtask : until_run

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : end_of_test

  initial begin
    repeat (40000) @(posedge pclk);
    err_count++;
    end_of_test();
  end

  initial begin
    presetn = 1'h0; ce = 1'h1; psel = 1'h0; penable = 1'h0; pwrite = 1'h0; paddr = '0; pwdata = '0;
    wait_req = 1'h0; halt_req = 1'h0; ext_wake = 1'h0;
    repeat (6) @(posedge pclk);
    presetn <= 1'h1;
    apb(1'h0, IDX_CSR, 8'h00);
    `MCC_CHK("csr_reset", 8'h00, rd[7:0])
    apb(1'h0, IDX_TONE, 8'h00);
    `MCC_CHK("tone_reset", 8'h00, rd[7:0])
    foreach (rows[i]) begin
      apb(1'h1, rows[i].idx, rows[i].wd);
      apb(1'h0, rows[i].idx, 8'h00);
      `MCC_CHK("readback", rows[i].ex & rows[i].m, rd[7:0] & rows[i].m)
      `MCC_CHK("slverr", rows[i].er, er)
      if (rows[i].ticks >= 0) begin
        n = 0;
        t0 = clk_edges;
        repeat (64) begin
          @(negedge pclk);
          n += (cpu_tick === 1'h1);
        end
        `MCC_CHK("cpu_ticks", rows[i].ticks, n)
        `MCC_CHK("clkout_edges", rows[i].wd[7] ? rows[i].ticks : 0, int'(clk_edges) - t0)
      end
    end
    apb(1'h1, IDX_IRQ_STATUS, 8'h01);
    p = 0;
    foreach (codes[j]) begin
      wait_irq(t0);
      apb(1'h1, IDX_CSR, 8'(codes[j] << 2));
      wait_irq(t1);
      wait_irq(t2);
      `MCC_CHK("old_period", DIV[p], t1 - t0)
      `MCC_CHK("period", DIV[codes[j]], t2 - t1)
      p = codes[j];
    end
    wait_irq(t0);
    apb(1'h0, IDX_CSR, 8'h00);
    `MCC_CHK("flag_set", 1'h1, rd[0])
    apb(1'h0, IDX_CSR, 8'h00);
    `MCC_CHK("flag_cleared", 1'h0, rd[0])
    apb(1'h1, IDX_IRQ_MASK, 8'h00);
    repeat (85) @(negedge pclk);
    `MCC_CHK("irq_masked", 1'h0, irq)
    apb(1'h0, IDX_IRQ_STATUS, 8'h00);
    `MCC_CHK("status_sticky", 1'h1, rd[0])
    apb(1'h1, IDX_IRQ_MASK, 8'h01);
    repeat (2) @(negedge pclk);
    `MCC_CHK("irq_unmasked", 1'h1, irq)
    apb(1'h1, IDX_IRQ_STATUS, 8'h01);
    repeat (2) @(negedge pclk);
    `MCC_CHK("irq_cleared", 1'h0, irq)
    for (int c = 3; c >= 0; c--) begin
      apb(1'h1, IDX_TONE, 8'(c));
      repeat (2 * HALF[c] + 20) @(negedge pclk);
      `MCC_CHK("tone_oe", c != 0, tone_oe)
      if (c != 0) `MCC_CHK("tone_half", HALF[c], tone_half)
      if (c == 0) `MCC_CHK("tone_off", 1'h0, tone_pin)
    end
    apb(1'h1, IDX_TONE, 8'h03);
    repeat (20) @(posedge pclk);
    ce <= 1'h0;
    // Listener runs free, so let the last pin change before the freeze be counted first
    repeat (2) @(posedge pclk);
    t0 = tone_edges;
    repeat (30) @(posedge pclk);
    `MCC_CHK("ce_freeze", t0, int'(tone_edges))
    ce <= 1'h1;
    apb(1'h1, IDX_CSR, 8'h82);
    wait_irq(t0);
    power_req(1'h1, 1'h0, 1'h0);
    `MCC_CHK("active_halt", PM_ACTIVE_HALT, power_mode)
    t0 = tone_edges;
    repeat (2) @(negedge pclk);
    `MCC_CHK("clkout_oe_halt", 1'h0, clock_out_oe)
    until_run();
    `MCC_CHK("tick_wake", PM_RUN, power_mode)
    `MCC_CHK("tone_in_halt", 1'h1, int'(tone_edges) != t0)
    apb(1'h1, IDX_CSR, 8'h80);
    power_req(1'h1, 1'h0, 1'h0);
    `MCC_CHK("full_halt", PM_HALT, power_mode)
    repeat (2) @(negedge pclk);
    t0 = tone_edges;
    repeat (60) @(negedge pclk);
    `MCC_CHK("no_tick_wake", PM_HALT, power_mode)
    `MCC_CHK("tone_frozen", t0, int'(tone_edges))
    power_req(1'h0, 1'h0, 1'h1);
    until_run();
    `MCC_CHK("ext_wake", PM_RUN, power_mode)
    apb(1'h1, IDX_CSR, 8'h02);
    wait_irq(t0);
    power_req(1'h0, 1'h1, 1'h0);
    `MCC_CHK("wait", PM_WAIT, power_mode)
    until_run();
    `MCC_CHK("wait_wake", PM_RUN, power_mode)
    end_of_test();
  end
endmodule : main_clock_rtc_beeper_tb
